// >>> uart_baud_pkg.sv
/*
 * Package for the serial baud select, frame error and oscillator trim block.
 * Holds register offsets, field positions, reset values and enumerations.
 * Assumes an 8-bit special function register port on the system clock.
 */
package uart_baud_pkg;

	// Register offsets on the special function register port.
	localparam logic [7:0] OSC_TRIM_HIGH_ADDR    = 8'h84;
	localparam logic [7:0] OSC_TRIM_LOW_ADDR     = 8'h85;
	localparam logic [7:0] TIMER3_UART_CTRL_ADDR = 8'hC4;
	localparam logic [7:0] SERIAL_CTRL_ADDR      = 8'h98;
	localparam logic [7:0] POWER_CTRL_ADDR       = 8'h87;
	localparam logic [7:0] CLOCK_CTRL_ADDR       = 8'h8E;
	localparam logic [7:0] T1_RELOAD_ADDR        = 8'h8D;
	localparam logic [7:0] T3_RELOAD_LOW_ADDR    = 8'hC5;
	localparam logic [7:0] T3_RELOAD_HIGH_ADDR   = 8'hC6;
	localparam logic [7:0] TIMED_ACCESS_ADDR     = 8'hC7;

	// Field positions.
	localparam int PORT1_DOUBLE_POS = 7;
	localparam int PORT1_FE_ACC_POS = 6;
	localparam int BAUD_SRC_POS     = 5;
	localparam int DOUBLE_POS       = 7;
	localparam int FE_ACCESS_POS    = 6;
	localparam int FE_MODE0_POS     = 7;
	localparam int MULTIPROC_POS    = 5;
	localparam int T1_CLKSEL_POS    = 4;

	// Reset values; the trim value is a neutral factory default.
	localparam logic [7:0] TIMER3_UART_CTRL_RST = 8'h00;
	localparam logic [7:0] SFR_RST              = 8'h00;
	localparam logic [8:0] OSC_TRIM_RST         = 9'h100;

	// Unlock key bytes.
	localparam logic [7:0] KEY_FIRST  = 8'hAA;
	localparam logic [7:0] KEY_SECOND = 8'h55;

	// Fixed dividers, counted in system clocks.
	localparam logic [6:0] MODE0_DIV_SLOW = 7'h0C;
	localparam logic [6:0] MODE0_DIV_FAST = 7'h02;
	localparam logic [6:0] MODE2_DIV_SLOW = 7'h40;
	localparam logic [6:0] MODE2_DIV_FAST = 7'h20;
	localparam logic [3:0] T1_PRE_DIV     = 4'hC;

	// Timer 3 overflows per bit time for each port.
	localparam logic [16:0] T3_PORT0_DIV      = 17'h00020;
	localparam logic [16:0] T3_PORT0_DIV_FAST = 17'h00010;
	localparam logic [16:0] PORT1_T3_DIV      = 17'h00010;

	// Unlock sequence states.
	typedef enum logic [1:0]
	{
		KEY_IDLE = 2'b00,
		KEY_HALF = 2'b01,
		KEY_OPEN = 2'b10
	} key_state_t;

	// Register port request.
	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sfr_req_t;

	// Received frame report from the shift logic.
	typedef struct packed
	{
		logic done;
		logic stopBit;
	} frame_rpt_t;

endpackage : uart_baud_pkg

// >>> baud_divider.sv
/*
 * Programmable tick divider: one pulse every divisor input events.
 * Assumes the divisor is at least one and held steady while running.
 */
`timescale 1ns/1ns
module baud_divider
(
	input  wire logic        clk,      // System clock.
	input  wire logic        reset_n,  // Synchronous reset, active low.
	input  wire logic        stepIn,   // Input event to count.
	input  wire logic [16:0] divisor,  // Events per output tick.
	output logic             tickOut   // One-cycle output tick.
);
	logic [16:0] count_ff;

	// A divisor change takes effect at the next input event; a count already past it wraps at once, giving a short tick.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			count_ff <= 17'h00000;
			tickOut  <= 1'b0;
		end
		else
		begin
			tickOut <= 1'b0;
			if (stepIn)
			begin
				if (count_ff + 17'h00001 >= divisor)
				begin
					count_ff <= 17'h00000;
					tickOut  <= 1'b1;
				end
				else
				begin
					count_ff <= count_ff + 17'h00001;
				end
			end
		end
	end
endmodule : baud_divider

// >>> uart_baud_select.sv
/*
 * Baud clock selection for both serial ports, frame error flag handling and
 * the internal oscillator trim registers behind a timed-access unlock.
 * Assumes a single-cycle register port and receive shift logic that reports
 * each finished frame with its sampled stop bit.
 */
`timescale 1ns/1ns
// Functional notes
// - Port 0 source: Timer 1 or Timer 3
// - Timer 1 baud: reload byte, divide 12
// - Clock select drops divide 12; avoid FFH
// - Timer 3 port 0: prescale, 16-bit reload
// - Nine-bit trim split over two registers
// - Trim resets to factory value, writes immediate
// - Frame check only in modes 1-3
// - Missing stop bit sets frame error
// - Access bit steers bit 7 meaning
// - Flag and mode bit stored separately
// - Flag sticky until software clears it
// - Mode 0 clock divide 12 or 2
// - Mode 2 clock divide 64 or 32
// - Port 1 uses Timer 3 only
module uart_baud_select
(
	input  wire logic                  clk,          // System clock.
	input  wire logic                  reset_n,      // Sync reset, low.
	input  wire uart_baud_pkg::sfr_req_t sfrReq,     // Register request.
	output logic [7:0]                 sfrRdata,     // Read data, next cycle.
	input  wire logic                  t1Overflow,   // Timer 1 overflow.
	input  wire logic                  t3Overflow,   // Timer 3 overflow.
	input  wire logic [1:0]            port0Mode,    // Port 0 mode.
	input  wire uart_baud_pkg::frame_rpt_t port0Rx,  // Port 0 frame end.
	output logic                       port0Tick,    // Port 0 baud tick.
	output logic                       port0ShiftTick, // Mode 0 shift.
	output logic                       port1Tick,    // Port 1 baud tick.
	output logic [8:0]                 oscTrim,      // Oscillator trim.
	output logic                       frameErr      // Frame error flag.
);
	logic [7:0]              t3Ctrl_ff;
	logic [7:0]              serCtrl_ff;
	logic [7:0]              powerCtrl_ff;
	logic [7:0]              clockCtrl_ff;
	logic [7:0]              t1Reload_ff;
	logic [7:0]              t3ReloadLow_ff;
	logic [7:0]              t3ReloadHigh_ff;
	logic [8:0]              trim_ff;
	logic                    frameErrFlag_ff;
	uart_baud_pkg::key_state_t keyState_ff;
	uart_baud_pkg::key_state_t nxt_keyState;
	logic [6:0]              sysDiv_ff;
	logic [3:0]              preDiv_ff;
	logic                    t1Step;
	logic [16:0]             t1Divisor;
	logic                    port0Raw;
	logic                    port0Sel;
	logic                    port0Fixed;
	logic [6:0]              fixedDiv;
	logic [16:0]             t3Divisor0;
	logic                    port0T3Tick;
	logic                    port1Raw;

	// Write decode used by every register process.
	function automatic logic hit(input uart_baud_pkg::sfr_req_t r,
		input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction : hit

	wire trimWrite = (keyState_ff == uart_baud_pkg::KEY_OPEN);
	wire feAccess  = powerCtrl_ff[uart_baud_pkg::FE_ACCESS_POS];
	wire doubleBit = powerCtrl_ff[uart_baud_pkg::DOUBLE_POS];
	wire asyncMode = (port0Mode != 2'b00);

	// Timed-access unlock: the key opens for exactly the next write.
	always_comb
	begin
		nxt_keyState = uart_baud_pkg::KEY_IDLE;
		if (sfrReq.wr)
		begin
			if (hit(sfrReq, uart_baud_pkg::TIMED_ACCESS_ADDR)
				&& sfrReq.wdata == uart_baud_pkg::KEY_FIRST)
			begin
				nxt_keyState = uart_baud_pkg::KEY_HALF;
			end
			else if (keyState_ff == uart_baud_pkg::KEY_HALF
				&& hit(sfrReq, uart_baud_pkg::TIMED_ACCESS_ADDR)
				&& sfrReq.wdata == uart_baud_pkg::KEY_SECOND)
			begin
				nxt_keyState = uart_baud_pkg::KEY_OPEN;
			end
		end
		else
		begin
			nxt_keyState = keyState_ff;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			keyState_ff <= uart_baud_pkg::KEY_IDLE;
		else
			keyState_ff <= nxt_keyState;
	end

	// Trim value; a write changes the oscillator output at once.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			trim_ff <= uart_baud_pkg::OSC_TRIM_RST;
		else if (trimWrite
			&& hit(sfrReq, uart_baud_pkg::OSC_TRIM_HIGH_ADDR))
			trim_ff[8:1] <= sfrReq.wdata;
		else if (trimWrite
			&& hit(sfrReq, uart_baud_pkg::OSC_TRIM_LOW_ADDR))
			trim_ff[0] <= sfrReq.wdata[0];
	end

	// Plain control registers.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			t3Ctrl_ff       <= uart_baud_pkg::TIMER3_UART_CTRL_RST;
			powerCtrl_ff    <= uart_baud_pkg::SFR_RST;
			clockCtrl_ff    <= uart_baud_pkg::SFR_RST;
			t1Reload_ff     <= uart_baud_pkg::SFR_RST;
			t3ReloadLow_ff  <= uart_baud_pkg::SFR_RST;
			t3ReloadHigh_ff <= uart_baud_pkg::SFR_RST;
		end
		else
		begin
			if (hit(sfrReq, uart_baud_pkg::TIMER3_UART_CTRL_ADDR))
				t3Ctrl_ff <= sfrReq.wdata;
			if (hit(sfrReq, uart_baud_pkg::POWER_CTRL_ADDR))
				powerCtrl_ff <= sfrReq.wdata;
			if (hit(sfrReq, uart_baud_pkg::CLOCK_CTRL_ADDR))
				clockCtrl_ff <= sfrReq.wdata;
			if (hit(sfrReq, uart_baud_pkg::T1_RELOAD_ADDR))
				t1Reload_ff <= sfrReq.wdata;
			if (hit(sfrReq, uart_baud_pkg::T3_RELOAD_LOW_ADDR))
				t3ReloadLow_ff <= sfrReq.wdata;
			if (hit(sfrReq, uart_baud_pkg::T3_RELOAD_HIGH_ADDR))
				t3ReloadHigh_ff <= sfrReq.wdata;
		end
	end

	// Serial control; bit 7 goes to the mode bit only while access is off.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			serCtrl_ff <= uart_baud_pkg::SFR_RST;
		else if (hit(sfrReq, uart_baud_pkg::SERIAL_CTRL_ADDR))
		begin
			serCtrl_ff[6:0] <= sfrReq.wdata[6:0];
			if (!feAccess)
				serCtrl_ff[7] <= sfrReq.wdata[7];
		end
	end

	wire feWrite = hit(sfrReq, uart_baud_pkg::SERIAL_CTRL_ADDR) && feAccess;
	wire feEvent = port0Rx.done && asyncMode && !port0Rx.stopBit;

	// Sticky flag: a bad stop bit in the same cycle as a clear still wins.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			frameErrFlag_ff <= 1'b0;
		else if (feEvent)
			frameErrFlag_ff <= 1'b1;
		else if (feWrite)
			frameErrFlag_ff <= sfrReq.wdata[uart_baud_pkg::FE_MODE0_POS];
	end

	// Read data stand in the cycle after the strobe only.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			sfrRdata <= 8'h00;
		else if (!sfrReq.rd)
			sfrRdata <= 8'h00;
		else
		begin
			case (sfrReq.addr)
				uart_baud_pkg::OSC_TRIM_HIGH_ADDR:    sfrRdata <= trim_ff[8:1];
				uart_baud_pkg::OSC_TRIM_LOW_ADDR:     sfrRdata <= {7'h00, trim_ff[0]};
				uart_baud_pkg::TIMER3_UART_CTRL_ADDR: sfrRdata <= t3Ctrl_ff;
				uart_baud_pkg::SERIAL_CTRL_ADDR:
					sfrRdata <= {feAccess ? frameErrFlag_ff : serCtrl_ff[7],
						serCtrl_ff[6:0]};
				uart_baud_pkg::POWER_CTRL_ADDR:       sfrRdata <= powerCtrl_ff;
				uart_baud_pkg::CLOCK_CTRL_ADDR:       sfrRdata <= clockCtrl_ff;
				uart_baud_pkg::T1_RELOAD_ADDR:        sfrRdata <= t1Reload_ff;
				uart_baud_pkg::T3_RELOAD_LOW_ADDR:    sfrRdata <= t3ReloadLow_ff;
				uart_baud_pkg::T3_RELOAD_HIGH_ADDR:   sfrRdata <= t3ReloadHigh_ff;
				default:                              sfrRdata <= 8'h00;
			endcase
		end
	end

	// Timer 1 prescale: divide by 12 unless the clock select bit is set.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			preDiv_ff <= 4'h0;
		else if (preDiv_ff == uart_baud_pkg::T1_PRE_DIV - 4'h1)
			preDiv_ff <= 4'h0;
		else
			preDiv_ff <= preDiv_ff + 4'h1;
	end

	// Timer 1 here is modelled as the reload-byte auto-reload counter.
	assign t1Step = clockCtrl_ff[uart_baud_pkg::T1_CLKSEL_POS]
		? 1'b1 : (preDiv_ff == 4'h0);
	// 32 times (256 - reload) steps per bit, halved by the double-rate bit.
	assign t1Divisor = ({9'h000, 8'hFF - t1Reload_ff} + 17'h00001)
		<< (doubleBit ? 4 : 5);

	baud_divider u_t1Div
	(
		.clk     (clk),
		.reset_n (reset_n),
		.stepIn  (t1Step),
		.divisor (t1Divisor),
		.tickOut (port0Raw)
	);

	// Timer 3 overflows already carry prescale and 16-bit reload, so port 0
	// only counts 32 overflows per bit, 16 when doubled. Port 1 counts 16
	// and ignores the port 0 double-rate bit.
	assign t3Divisor0 = doubleBit ? uart_baud_pkg::T3_PORT0_DIV_FAST
		: uart_baud_pkg::T3_PORT0_DIV;

	baud_divider u_t3Div0
	(
		.clk     (clk),
		.reset_n (reset_n),
		.stepIn  (t3Overflow),
		.divisor (t3Divisor0),
		.tickOut (port0T3Tick)
	);

	baud_divider u_t3Div1
	(
		.clk     (clk),
		.reset_n (reset_n),
		.stepIn  (t3Overflow),
		.divisor (uart_baud_pkg::PORT1_T3_DIV),
		.tickOut (port1Raw)
	);

	// Port 0 source for modes 1 and 3.
	assign port0Sel = t3Ctrl_ff[uart_baud_pkg::BAUD_SRC_POS]
		? port0T3Tick : port0Raw;

	// Fixed rate divider for modes 0 and 2.
	always_comb
	begin
		case (port0Mode)
			2'b00: fixedDiv = serCtrl_ff[uart_baud_pkg::MULTIPROC_POS]
				? uart_baud_pkg::MODE0_DIV_FAST
				: uart_baud_pkg::MODE0_DIV_SLOW;
			2'b10: fixedDiv = doubleBit ? uart_baud_pkg::MODE2_DIV_FAST
				: uart_baud_pkg::MODE2_DIV_SLOW;
			default: fixedDiv = uart_baud_pkg::MODE0_DIV_SLOW;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			sysDiv_ff <= 7'h00;
		else if (sysDiv_ff + 7'h01 >= fixedDiv)
			sysDiv_ff <= 7'h00;
		else
			sysDiv_ff <= sysDiv_ff + 7'h01;
	end
	assign port0Fixed = (sysDiv_ff == 7'h00);

	// Registered outputs; each port tick marks one bit time.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			port0Tick      <= 1'b0;
			port0ShiftTick <= 1'b0;
			port1Tick      <= 1'b0;
		end
		else
		begin
			port0ShiftTick <= (port0Mode == 2'b00) && port0Fixed;
			port0Tick <= (port0Mode == 2'b10) ? port0Fixed
				: (port0Mode != 2'b00) && port0Sel;
			port1Tick <= port1Raw;
		end
	end

	assign oscTrim  = trim_ff;
	assign frameErr = frameErrFlag_ff;

	a_fe_sticky: assert property (@(posedge clk)
		disable iff (!reset_n)
		frameErrFlag_ff && !feWrite |=> frameErrFlag_ff)
		else $error("frame error flag dropped without a write");
	a_fe_set: assert property (@(posedge clk)
		disable iff (!reset_n)
		feEvent |=> frameErrFlag_ff)
		else $error("bad stop bit did not set frame error");
	a_fe_mode0: assert property (@(posedge clk)
		disable iff (!reset_n)
		port0Rx.done && !asyncMode && !feWrite
		|=> $stable(frameErrFlag_ff))
		else $error("frame error changed in mode 0");
	a_mode_bit_kept: assert property (@(posedge clk)
		disable iff (!reset_n)
		feWrite |=> $stable(serCtrl_ff[7]))
		else $error("mode bit changed by flag write");
	sequence keyOpen;
		hit(sfrReq, uart_baud_pkg::TIMED_ACCESS_ADDR)
			&& sfrReq.wdata == uart_baud_pkg::KEY_FIRST
		##1 hit(sfrReq, uart_baud_pkg::TIMED_ACCESS_ADDR)
			&& sfrReq.wdata == uart_baud_pkg::KEY_SECOND;
	endsequence
	a_trim_locked: assert property (@(posedge clk)
		disable iff (!reset_n)
		!trimWrite |=> $stable(trim_ff))
		else $error("trim changed without unlock");
	a_trim_write: assert property (@(posedge clk)
		disable iff (!reset_n)
		keyOpen ##1 hit(sfrReq, uart_baud_pkg::OSC_TRIM_HIGH_ADDR)
		|=> trim_ff[8:1] == $past(sfrReq.wdata))
		else $error("unlocked trim write lost");
	a_key_close: assert property (@(posedge clk)
		disable iff (!reset_n)
		keyState_ff == uart_baud_pkg::KEY_OPEN && sfrReq.wr
		|=> keyState_ff != uart_baud_pkg::KEY_OPEN)
		else $error("trim key stayed open after a write");
	a_src_t3: assert property (@(posedge clk)
		disable iff (!reset_n)
		port0Mode == 2'b01 && t3Ctrl_ff[uart_baud_pkg::BAUD_SRC_POS]
		|=> port0Tick == $past(port0T3Tick))
		else $error("port 0 not fed from Timer 3");
	a_port1_src: assert property (@(posedge clk)
		disable iff (!reset_n)
		port1Raw |=> port1Tick)
		else $error("port 1 tick missing");
	a_port1_step: assert property (@(posedge clk)
		disable iff (!reset_n)
		port1Tick |-> $past(t3Overflow, 2))
		else $error("port 1 tick without Timer 3 overflow");
	a_shift_mode0: assert property (@(posedge clk)
		disable iff (!reset_n)
		port0ShiftTick |-> $past(port0Mode) == 2'b00)
		else $error("shift tick outside mode 0");
endmodule : uart_baud_select

// >>> remote_serial_model.sv
/*
 * Far-side model: a remote sender reporting each frame end with its stop
 * bit, plus the Timer 3 overflow stream. Assumes the shared system clock.
 */
`timescale 1ns/1ns
module remote_serial_model
(
	input  wire logic                 clk,        // System clock.
	input  wire logic                 reset_n,    // Sync reset, low.
	input  wire logic                 sendFrame,  // End one frame.
	input  wire logic                 goodStop,   // Its stop bit.
	input  wire logic [7:0]           t3Period,   // Clocks per overflow.
	output uart_baud_pkg::frame_rpt_t port0Rx,    // Frame end report.
	output logic                      t3Overflow  // Overflow pulse.
);
	logic [7:0] cnt_ff;

	// Between frames the stop line shows the inverse of its last value,
	// so a stale level can never pass for a real stop bit.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			port0Rx <= '0;
		else if (sendFrame)
			port0Rx <= {1'h1, goodStop};
		else
			port0Rx <= {1'h0, ~port0Rx.stopBit};
	end

	// Overflow stream: one pulse every t3Period clocks, down to every clock,
	// and none while t3Period is zero; this timer raises no interrupt.
	always_ff @(posedge clk)
	begin
		if (!reset_n || t3Period == 8'h00)
		begin
			cnt_ff     <= 8'h00;
			t3Overflow <= 1'h0;
		end
		else
		begin
			cnt_ff     <= (cnt_ff >= t3Period - 8'h01) ? 8'h00 : cnt_ff + 8'h01;
			t3Overflow <= (cnt_ff == t3Period - 8'h01);
		end
	end
endmodule : remote_serial_model

// >>> tb_uart_baud_select.sv
/*
 * Self-checking bench for the baud select block: register port, trim key,
 * frame error flag and tick spacing. Assumes the far-side model file.
 */
`timescale 1ns/1ns
module tb_uart_baud_select;
	logic                      clk;
	logic                      reset_n;
	uart_baud_pkg::sfr_req_t   sfrReq;
	logic [7:0]                sfrRdata;
	logic [1:0]                port0Mode;
	uart_baud_pkg::frame_rpt_t port0Rx;
	logic                      t3Overflow;
	logic                      port0Tick;
	logic                      port0ShiftTick;
	logic                      port1Tick;
	logic                      frameErr;
	logic [8:0]                oscTrim;
	logic                      sendFrame;
	logic                      goodStop;
	logic                      rdSeen;
	logic [7:0]                t3Period;
	logic [15:0]               expQ[$];
	logic [15:0]               e;
	logic [31:0]               seed;
	logic [8:0]                r9;
	int                        num_errors;
	int                        comparisons;

	uart_baud_select uart_baud_select_i (.clk(clk), .reset_n(reset_n),
		.sfrReq(sfrReq), .sfrRdata(sfrRdata), .t1Overflow(1'h0),
		.t3Overflow(t3Overflow), .port0Mode(port0Mode), .port0Rx(port0Rx),
		.port0Tick(port0Tick), .port0ShiftTick(port0ShiftTick),
		.port1Tick(port1Tick), .oscTrim(oscTrim), .frameErr(frameErr));
	remote_serial_model remote_serial_model_i (.clk(clk), .reset_n(reset_n),
		.sendFrame(sendFrame), .goodStop(goodStop), .t3Period(t3Period),
		.port0Rx(port0Rx), .t3Overflow(t3Overflow));

	// Free-running system clock, 8 ns period.
	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	function logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function logic tk(input int s);
		return (s == 0) ? port0Tick : (s == 1) ? port0ShiftTick : port1Tick;
	endfunction : tk

	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task report_and_stop;
		if (num_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop

	// Bus cycles: each drives just after a rising edge and holds one cycle.
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfrReq <= {a, d, 2'h2};
		@(posedge clk);
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
		sfrReq <= {a, 8'h00, 2'h1};
		expQ.push_back({m, x});
		@(posedge clk);
	endtask : rd

	task idle;
		sfrReq <= '0;
		@(posedge clk);
	endtask : idle

	task key;
		wr(8'hC7, 8'hAA);
		wr(8'hC7, 8'h55);
	endtask : key

	// Settled outputs are looked at mid-cycle, then back to a rising edge.
	task look(input logic [15:0] seen_unused, input logic [15:0] exp);
		@(negedge clk);
		check({7'h00, oscTrim} & 16'h01FF | {15'h0000, 1'h0}, 16'h0000 | exp);
		@(posedge clk);
	endtask : look

	task lookErr(input logic exp);
		@(negedge clk);
		check({15'h0000, frameErr}, {15'h0000, exp});
		@(posedge clk);
	endtask : lookErr

	task frame(input logic good);
		sfrReq    <= '0;
		sendFrame <= 1'h1;
		goodStop  <= good;
		@(posedge clk);
		sendFrame <= 1'h0;
		repeat (3) @(posedge clk);
	endtask : frame

	// Skips one tick so a stale count cannot land, then measures a gap.
	task gap(input int s, input int exp);
		int n;
		n = 0;
		repeat (2)
		begin
			@(negedge clk);
			while (!tk(s) && n < 3000)
			begin
				@(negedge clk);
				n++;
			end
		end
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end while (!tk(s) && n < 3000);
		check(16'(n), 16'(exp));
		@(posedge clk);
	endtask : gap

	// Read results stand only in the cycle after the strobe; the oldest
	// note is compared then.
	always @(negedge clk)
	begin
		if (rdSeen)
		begin
			e = expQ.pop_front();
			check({8'h00, sfrRdata & e[15:8]}, {8'h00, e[7:0]});
		end
		rdSeen = sfrReq.rd;
	end

	// Watchdog sized well beyond the whole sequence.
	initial
	begin
		#(8 * 50000);
		num_errors++;
		report_and_stop();
	end

	initial
	begin
		reset_n = 1'h0;
		sfrReq = '0;
		port0Mode = 2'h0;
		sendFrame = 1'h0;
		goodStop = 1'h1;
		t3Period = 8'h00;
		rdSeen = 1'h0;
		seed = 32'h00012C32;
		num_errors = 0;
		comparisons = 0;
		repeat (16) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		look(16'h0000, 16'h0100);
		lookErr(1'h0);
		rd(8'hC4, 8'hFF, 8'h00);
		rd(8'h90, 8'hFF, 8'h00);
		// A broken key and a bare write both leave the trim alone.
		wr(8'h84, 8'h00);
		wr(8'hC7, 8'hAA);
		wr(8'h87, 8'h00);
		wr(8'hC7, 8'h55);
		wr(8'h84, 8'h00);
		idle();
		look(16'h0000, 16'h0100);
		// Lower by 15; a read between key and write does not close it.
		key();
		wr(8'h84, 8'h78);
		key();
		rd(8'h84, 8'hFF, 8'h78);
		wr(8'h85, 8'h01);
		idle();
		look(16'h0000, 16'h00F1);
		seed = xs(seed);
		r9 = seed[8:0];
		key();
		wr(8'h84, r9[8:1]);
		key();
		wr(8'h85, {seed[15:9], r9[0]});
		idle();
		look(16'h0000, {7'h00, r9});
		rd(8'h85, 8'hFF, {7'h00, r9[0]});
		wr(8'hC4, seed[23:16]);
		rd(8'hC4, 8'hFF, seed[23:16]);
		// Frame errors: never in mode 0, sticky in modes 1 to 3.
		wr(8'h87, 8'h40);
		frame(1'h0);
		lookErr(1'h0);
		for (int m = 1; m < 4; m++)
		begin
			port0Mode <= m[1:0];
			frame(1'h0);
			lookErr(1'h1);
			frame(1'h1);
			lookErr(1'h1);
			rd(8'h98, 8'h80, 8'h80);
			wr(8'h98, 8'h00);
			idle();
			lookErr(1'h0);
		end
		seed = xs(seed);
		frame(1'h0);
		wr(8'h87, 8'h00);
		wr(8'h98, {seed[0], 7'h00});
		idle();
		lookErr(1'h1);
		rd(8'h98, 8'h80, {seed[0], 7'h00});
		wr(8'h87, 8'h40);
		rd(8'h98, 8'h80, 8'h80);
		wr(8'h98, 8'h00);
		wr(8'h87, 8'h00);
		rd(8'h98, 8'h80, {seed[0], 7'h00});
		// Tick spacing for every source and for modes 0 to 2. Rates far above the
		// advised limit for the slow oscillator only shorten the run.
		t3Period <= 8'h14;
		port0Mode <= 2'h1;
		wr(8'hC4, 8'h20);
		idle();
		gap(0, 640);
		gap(2, 320);
		wr(8'h87, 8'h80);
		idle();
		gap(0, 320);
		gap(2, 320);
		wr(8'h87, 8'h00);
		wr(8'hC4, 8'h00);
		wr(8'h8D, 8'hFE);
		wr(8'h8E, 8'h10);
		idle();
		gap(0, 64);
		wr(8'h87, 8'h80);
		idle();
		gap(0, 32);
		wr(8'h8E, 8'h00);
		idle();
		gap(0, 384);
		port0Mode <= 2'h2;
		gap(0, 32);
		wr(8'h87, 8'h00);
		idle();
		gap(0, 64);
		port0Mode <= 2'h0;
		wr(8'h98, 8'h00);
		idle();
		gap(1, 12);
		wr(8'h98, 8'h20);
		idle();
		gap(1, 2);
		report_and_stop();
	end
endmodule : tb_uart_baud_select
